// file: core/reset_brownout_sequencer.sv
// reset sequencer: power-on hold, power-up timer, brown-out unit and control register
//
// Local design decisions: register access over APB and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "rst_seq_params.svh"
module reset_brownout_sequencer #(
    parameter int unsigned POWER_UP_CYCLES = `POWER_UP_CYCLES
) (
    // clock and reset
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    // apb slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [11:0]           paddr,
    input  wire logic [31:0]           pwdata,
    input  wire logic [3:0]            pstrb,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    // configuration and sources
    input  wire rst_seq_pkg::cfg_t     cfg,
    input  wire rst_seq_pkg::rst_src_t src,
    input  wire logic                  sleep_req,
    // analog and core controls
    output logic                       brownout_enable,
    output logic                       brownout_level,
    output logic                       bandgap_force_on,
    output logic                       core_reset_n,
    output logic                       wake_hold,
    output logic                       brownout_reset_flag
);
    import rst_seq_pkg::*;

    localparam int unsigned FILT_W     = $clog2(`FILTER_CYCLES + 1);
    localparam int unsigned PUT_W      = $clog2(POWER_UP_CYCLES + 1);
    localparam int unsigned NSRC       = $bits(rst_src_t);
    localparam logic [7:0]  CTRL_RESET = `BROWNOUT_CTRL_RESET;

    // two-flop synchronisers, one per source bit
    // only the second stage is read, so a metastable first stage never fans out
    logic [NSRC-1:0] sync1_reg;
    logic [NSRC-1:0] sync2_reg;
    genvar gi;
    generate
        for (gi = 0; gi < NSRC; gi++) begin : g_sync
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    sync1_reg[gi] <= 1'b0;
                    sync2_reg[gi] <= 1'b0;
                end else begin
                    sync1_reg[gi] <= src[gi];
                    sync2_reg[gi] <= sync1_reg[gi];
                end
            end
        end
    endgenerate

    rst_src_t s;
    assign s = rst_src_t'(sync2_reg);

    // control register state
    logic sw_en_reg;
    logic fast_reg;
    logic rdy_reg;
    logic asleep_reg;

    // bus decode; only byte lane 0 carries the writable bits
    wire  hit        = (paddr == `BROWNOUT_CTRL_ADDR);
    wire  acc        = psel && penable;
    wire  wr_ok      = acc && pwrite && hit && pstrb[0];
    wire  setup_ph   = psel && !penable;

    // mode decode
    wire  mode_sw    = (cfg.brownout_mode_select == MODE_SOFTWARE);
    wire  mode_on    = (cfg.brownout_mode_select == MODE_ALWAYS_ON);
    wire  mode_noslp = (cfg.brownout_mode_select == MODE_OFF_IN_SLEEP);
    wire  mode_off   = (cfg.brownout_mode_select == MODE_ALWAYS_OFF);

    // brown-out circuit enable per mode
    wire  bo_en_next = mode_on
                    || (mode_noslp && !asleep_reg)
                    || (mode_sw && sw_en_reg);
    wire  fast_next  = (mode_noslp || mode_sw) && fast_reg;

    logic              bo_en_reg;
    logic [FILT_W-1:0] ready_cnt_reg;
    wire               ready_done;
    wire               ready_next;
    assign ready_done = (ready_cnt_reg == FILT_W'(`READY_CYCLES));
    assign ready_next = bo_en_reg && ready_done;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sw_en_reg     <= CTRL_RESET[`SW_ENABLE_BIT];
            fast_reg      <= CTRL_RESET[`FAST_START_BIT];
            bo_en_reg     <= 1'b0;
            ready_cnt_reg <= '0;
            rdy_reg       <= 1'b0;
            asleep_reg    <= 1'b0;
        end else begin
            if (wr_ok) begin
                sw_en_reg <= pwdata[`SW_ENABLE_BIT];
                fast_reg  <= pwdata[`FAST_START_BIT];
            end
            bo_en_reg <= bo_en_next;
            // settle time of the analog circuit, or its own ready output
            if (!bo_en_reg)
                ready_cnt_reg <= '0;
            else if (!ready_done)
                ready_cnt_reg <= ready_cnt_reg + 1'b1;
            rdy_reg    <= ready_next || (bo_en_reg && s.brownout_analog_ready);
            // sleep is only honoured once the core runs
            asleep_reg <= sleep_req && core_reset_n;
        end
    end

    // brown-out filter: low supply must outlast the filter time
    // a short glitch restarts the count, so only one long dip trips
    logic [FILT_W-1:0] filt_cnt_reg;
    logic              trip_reg;
    wire               low_sup;
    wire               filt_done;
    assign low_sup   = s.supply_below_brownout && rdy_reg;
    assign filt_done = (filt_cnt_reg == FILT_W'(`FILTER_CYCLES));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            filt_cnt_reg <= '0;
            trip_reg     <= 1'b0;
        end else begin
            if (!low_sup)
                filt_cnt_reg <= '0;
            else if (!filt_done)
                filt_cnt_reg <= filt_cnt_reg + 1'b1;
            trip_reg <= low_sup && filt_done;
        end
    end

    // power-on/brown-out hold
    wire  lp_low     = cfg.low_power_brownout_en && s.supply_below_low_power;
    wire  por_hold   = s.supply_below_por || s.prog_mode_exit;
    wire  bo_hold    = trip_reg || lp_low;
    wire  supply_hold = por_hold || bo_hold;

    // always-on and off-in-sleep start-up waits for ready and good supply
    wire  start_wait = (mode_on || mode_noslp)
                    && (!rdy_reg || s.supply_below_brownout);

    // power-up timer: counts only once both supply holds are gone
    logic [PUT_W-1:0] pu_cnt_reg;
    logic             pu_done_reg;
    wire              pu_last;
    assign pu_last = (pu_cnt_reg == PUT_W'(POWER_UP_CYCLES - 1));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pu_cnt_reg  <= '0;
            pu_done_reg <= 1'b0;
        end else if (supply_hold) begin
            pu_cnt_reg  <= '0;
            pu_done_reg <= 1'b0;
        end else if (!pu_done_reg) begin
            if (cfg.power_up_timer_disable)
                pu_done_reg <= 1'b1;
            else if (pu_last)
                pu_done_reg <= 1'b1;
            else
                pu_cnt_reg <= pu_cnt_reg + 1'b1;
        end
    end

    // other reset sources; pin does not touch the timer
    wire  soft_rst   = !s.external_reset_pin_n
                    || s.watchdog_reset
                    || s.reset_instruction
                    || s.stack_overflow
                    || s.stack_underflow;

    // the start-up wait gates release only; once running, a falling ready
    // (sleep in off-in-sleep mode) must not throw the core back into reset
    wire  hold_run   = !pu_done_reg || soft_rst || supply_hold;
    wire  hold_start = hold_run || start_wait;

    // release counter: core leaves reset a fixed count after the last hold
    logic [3:0] rel_cnt_reg;
    wire        rel_last;
    wire        rel_next;
    assign rel_last = (rel_cnt_reg == 4'(`PIN_RELEASE_CYCLES - 1));
    assign rel_next = !hold_start && rel_last;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rel_cnt_reg  <= '0;
            core_reset_n <= 1'b0;
        end else begin
            if (hold_start)
                rel_cnt_reg <= '0;
            else if (!rel_last)
                rel_cnt_reg <= rel_cnt_reg + 1'b1;
            core_reset_n <= core_reset_n ? !hold_run : rel_next;
        end
    end

    // outputs and bus answer
    // zero wait states: the answer is registered in the setup cycle and
    // stands through the access cycle
    wire [31:0] rd_word = {24'h000000, sw_en_reg, fast_reg, 5'h00, rdy_reg};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata              <= 32'h00000000;
            pready              <= 1'b0;
            pslverr             <= 1'b0;
            brownout_enable     <= 1'b0;
            brownout_level      <= 1'b0;
            bandgap_force_on    <= 1'b0;
            wake_hold           <= 1'b0;
            brownout_reset_flag <= 1'b0;
        end else begin
            pready              <= setup_ph;
            pslverr             <= setup_ph && !hit;
            prdata              <= (setup_ph && !pwrite && hit) ? rd_word : 32'h00000000;
            brownout_enable     <= bo_en_reg;
            brownout_level      <= cfg.brownout_level_select;
            bandgap_force_on    <= fast_next;
            // wake waits only in off-in-sleep; always-on sets ready before execution
            wake_hold           <= mode_noslp && !rdy_reg;
            brownout_reset_flag <= bo_hold;
        end
    end

    // timer and reset hold

    a_timer_holds_reset: assert property (@(posedge pclk) disable iff (!presetn)
        !pu_done_reg |=> !core_reset_n)
        else $error("reset released during timer");

    a_timer_restart: assert property (@(posedge pclk) disable iff (!presetn)
        supply_hold |=> !pu_done_reg)
        else $error("timer ran during supply hold");

    a_timer_skipped: assert property (@(posedge pclk) disable iff (!presetn)
        (!supply_hold && cfg.power_up_timer_disable) |=> pu_done_reg)
        else $error("disabled timer still counting");

    a_por_holds: assert property (@(posedge pclk) disable iff (!presetn)
        por_hold |=> !core_reset_n)
        else $error("reset released with low supply");

    a_low_power_hold: assert property (@(posedge pclk) disable iff (!presetn)
        lp_low |=> !core_reset_n)
        else $error("low-power detector ignored");

    a_start_waits: assert property (@(posedge pclk) disable iff (!presetn)
        (!core_reset_n && start_wait) |=> !core_reset_n)
        else $error("start-up did not wait for ready");

    a_pin_release: assert property (@(posedge pclk) disable iff (!presetn)
        ($fell(soft_rst) && pu_done_reg && !hold_start) |-> !core_reset_n [*8])
        else $error("pin release too early");

    // brown-out filter and enable

    a_filter_gate: assert property (@(posedge pclk) disable iff (!presetn)
        !low_sup |=> !trip_reg)
        else $error("brownout without filtered low");

    a_sw_mode_en: assert property (@(posedge pclk) disable iff (!presetn)
        (mode_sw && !sw_en_reg) |=> !bo_en_reg)
        else $error("sw mode enable ignored");

    a_sw_mode_on: assert property (@(posedge pclk) disable iff (!presetn)
        (mode_sw && sw_en_reg) |=> bo_en_reg)
        else $error("sw mode enable not applied");

    a_on_mode_en: assert property (@(posedge pclk) disable iff (!presetn)
        mode_on |=> bo_en_reg)
        else $error("always-on not enabled");

    a_noslp_sleep: assert property (@(posedge pclk) disable iff (!presetn)
        (mode_noslp && asleep_reg) |=> !bo_en_reg)
        else $error("brownout on in sleep");

    a_ready_status: assert property (@(posedge pclk) disable iff (!presetn)
        !bo_en_reg |=> !rdy_reg)
        else $error("ready set with circuit off");

    // band gap, wake and level outputs

    a_fast_ignored: assert property (@(posedge pclk) disable iff (!presetn)
        (mode_on || mode_off) |=> !bandgap_force_on)
        else $error("fast start acted in fixed mode");

    a_fast_applied: assert property (@(posedge pclk) disable iff (!presetn)
        ((mode_noslp || mode_sw) && fast_reg) |=> bandgap_force_on)
        else $error("fast start not applied");

    a_no_wake_wait: assert property (@(posedge pclk) disable iff (!presetn)
        mode_on |=> !wake_hold)
        else $error("always-on delayed wake");

    a_level_follow: assert property (@(posedge pclk) disable iff (!presetn)
        1'b1 |=> (brownout_level == $past(cfg.brownout_level_select)))
        else $error("trip level not passed on");

    // bus answer

    a_error_with_ready: assert property (@(posedge pclk) disable iff (!presetn)
        pslverr |-> pready)
        else $error("error without ready");

    // main scenarios

    c_release: cover property (@(posedge pclk) disable iff (!presetn)
        $rose(core_reset_n));

    c_trip: cover property (@(posedge pclk) disable iff (!presetn)
        $rose(trip_reg));

    c_sw_write: cover property (@(posedge pclk) disable iff (!presetn)
        wr_ok && mode_sw);

    c_noslp_sleep: cover property (@(posedge pclk) disable iff (!presetn)
        mode_noslp && asleep_reg && core_reset_n);

    c_timer_skip: cover property (@(posedge pclk) disable iff (!presetn)
        cfg.power_up_timer_disable && $rose(pu_done_reg));
endmodule
`default_nettype wire

// file: pkg/rst_seq_params.svh
// register map, field positions, reset values and timing counts for the reset sequencer
// How it works
// - nine reset sources all force core reset
// - hold reset while supply below minimum
// - power-up timer gives nominal 64 ms
// - reset held until power-up timer expires
// - power-up timer enabled when disable bit low
// - timer starts after power-on and brown-out release
// - two-bit mode field selects brown-out mode
// - configuration bit selects brown-out trip level
// - brown-out only after low supply outlasts filter; the low-power detector (low_power_brownout_en) holds reset unfiltered
// - always-on start-up waits ready and supply
// - always-on: active in sleep, no wake wait
// - off-in-sleep: disabled asleep, wake waits ready
// - software mode: no start-up wait, enable decides
// - software mode protects once ready, sleep ignored
// - forced-on modes set ready before execution
// - enable bit 7 acts only in software mode
// - fast-start bit 6 forces band gap on
// - fast-start ignored in always-on and always-off
// - ready bit 0 shows circuit active
// - timer ignores pin; pin release waits 10 cycles
`ifndef RST_SEQ_PARAMS_SVH
`define RST_SEQ_PARAMS_SVH
`define BROWNOUT_CTRL_ADDR  12'h000
`define BROWNOUT_CTRL_RESET 8'h80
`define SW_ENABLE_BIT       7
`define FAST_START_BIT      6
`define READY_STATUS_BIT    0
`define CLK_FREQ_HZ         125000000
`define POWER_UP_TIME_MS    64
`define POWER_UP_CYCLES     ((`CLK_FREQ_HZ / 1000) * `POWER_UP_TIME_MS)
`define PIN_RELEASE_CYCLES  10
`define FILTER_TIME_NS      1000
`define FILTER_CYCLES       (`FILTER_TIME_NS / 8)
`define READY_TIME_NS       800
`define READY_CYCLES        ((`READY_TIME_NS + 7) / 8)
`endif

// file: pkg/rst_seq_pkg.sv
// types for the reset sequencer
package rst_seq_pkg;
    typedef enum logic [1:0] {
        MODE_ALWAYS_OFF   = 2'h0,
        MODE_SOFTWARE     = 2'h1,
        MODE_OFF_IN_SLEEP = 2'h2,
        MODE_ALWAYS_ON    = 2'h3
    } bor_mode_t;

    // configuration word fields seen by the sequencer
    typedef struct packed {
        bor_mode_t brownout_mode_select;
        logic      brownout_level_select;
        logic      power_up_timer_disable;
        logic      low_power_brownout_en;
    } cfg_t;

    // asynchronous detector and reset request inputs
    typedef struct packed {
        logic supply_below_por;
        logic supply_below_brownout;
        logic supply_below_low_power;
        logic brownout_analog_ready;
        logic external_reset_pin_n;
        logic watchdog_reset;
        logic reset_instruction;
        logic stack_overflow;
        logic stack_underflow;
        logic prog_mode_exit;
    } rst_src_t;
endpackage

// file: verif/detector_model.sv
// behavioural model of the analog supply detectors beside the sequencer
`timescale 1ns/10ps
`default_nettype none
module detector_model (
    // clock
    input  wire logic pclk,
    // detector enable and commanded supply state
    input  wire logic enable,
    input  wire logic vdd_por_low,
    input  wire logic vdd_brownout_low,
    // detector outputs
    output logic      below_por,
    output logic      below_brownout,
    output logic      ready
);
    logic [2:0] settle_reg;
    // an unsettled or disabled brown-out comparator cannot report a low supply
    assign below_por = vdd_por_low;
    assign below_brownout = vdd_brownout_low & ready;
    assign ready     = enable & (settle_reg == 3'h5);
    always_ff @(posedge pclk) begin
        if (!enable)
            settle_reg <= 3'h0;
        else if (settle_reg != 3'h5)
            settle_reg <= settle_reg + 3'h1;
    end
endmodule
`default_nettype wire

// file: verif/test_reset_brownout_sequencer.sv
// self-checking bench for the reset and brown-out sequencer
`timescale 1ns/10ps
`default_nettype none
module test_reset_brownout_sequencer;
    import rst_seq_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, slverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, e, lfsr;
    logic [3:0]  pstrb;
    logic        sleep_req, bo_en, bo_lvl, bg_on, core_reset_n, wake_hold, bo_flag;
    logic        por_low, bo_low, below_por, below_bo, ready;
    logic [5:0]  req;
    cfg_t        cfg;
    rst_src_t    src;
    int          err_count, n_checks, n, k;

    assign src = {below_por, below_bo, 1'b0, ready, ~req[5], req[4:0]};

    reset_brownout_sequencer #(.POWER_UP_CYCLES(50)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cfg(cfg), .src(src), .sleep_req(sleep_req),
        .brownout_enable(bo_en), .brownout_level(bo_lvl), .bandgap_force_on(bg_on),
        .core_reset_n(core_reset_n), .wake_hold(wake_hold), .brownout_reset_flag(bo_flag));

    detector_model model (.pclk(pclk), .enable(bo_en), .vdd_por_low(por_low),
        .vdd_brownout_low(bo_low), .below_por(below_por), .below_brownout(below_bo),
        .ready(ready));

    function automatic logic [31:0] next_lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    task automatic test_done();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        n_checks++;
        if (g !== x) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, x, g);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 20);
        if (pready !== 1'b1) begin
            err_count++;
            test_done();
        end
        rd = prdata;
        slverr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // bounded wait for the core reset level, n holds the cycles taken
    task automatic wait_core(input logic lvl);
        n = 0;
        while (core_reset_n !== lvl && n < 1000) begin
            @(posedge pclk);
            n++;
        end
        if (core_reset_n !== lvl) begin
            err_count++;
            test_done();
        end
    endtask

    task automatic settle(input logic [1:0] m);
        cfg.brownout_mode_select <= bor_mode_t'(m);
        repeat (4) @(posedge pclk);
    endtask

    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, sleep_req, bo_low, req} = '0;
        pstrb = 4'hF;
        por_low = 1'b1;
        lfsr = 32'h1F4134DC;
        cfg = '{MODE_ALWAYS_OFF, 1'b1, 1'b0, 1'b0};
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        repeat (5) @(posedge pclk);
        chk("core_reset_n por", 1'b0, core_reset_n);
        por_low <= 1'b0;
        wait_core(1'b1);
        chk("timer length", 1'b1, n >= 50);
        chk("brownout_level", 1'b1, bo_lvl);
        apb(1'b0, 12'h000, 32'h0, 4'hF);
        chk("reset value", 32'h80, rd & 32'hFE);
        apb(1'b0, 12'h004, 32'h0, 4'hF);
        chk("unmapped err", 1'b1, slverr);
        chk("unmapped data", 32'h0, rd);
        repeat (4) begin
            lfsr = next_lfsr(lfsr);
            e = lfsr & 32'hC0;
            apb(1'b1, 12'h000, lfsr, 4'hF);
            apb(1'b0, 12'h000, 32'h0, 4'hF);
            chk("readback", e, rd & 32'hFE);
        end
        apb(1'b1, 12'h000, ~e, 4'h0);
        apb(1'b0, 12'h000, 32'h0, 4'hF);
        chk("strobe off", e, rd & 32'hFE);
        apb(1'b1, 12'h000, 32'h80, 4'hF);
        settle(2'h0);
        chk("enable mode off", 1'b0, bo_en);
        settle(2'h1);
        chk("enable sw on", 1'b1, bo_en);
        repeat (8) @(posedge pclk);
        apb(1'b0, 12'h000, 32'h0, 4'hF);
        chk("ready bit", 1'b1, rd[0]);
        apb(1'b1, 12'h000, 32'h40, 4'hF);
        settle(2'h1);
        chk("enable sw off", 1'b0, bo_en);
        settle(2'h2);
        chk("bandgap forced", 1'b1, bg_on);
        settle(2'h3);
        chk("bandgap ignored", 1'b0, bg_on);
        sleep_req <= 1'b1;
        settle(2'h3);
        chk("on in sleep", 1'b1, bo_en);
        chk("no wake hold", 1'b0, wake_hold);
        settle(2'h2);
        chk("off in sleep", 1'b0, bo_en);
        sleep_req <= 1'b0;
        settle(2'h3);
        repeat (10) @(posedge pclk);
        // a glitch shorter than the filter must leave the core running
        bo_low <= 1'b1;
        repeat (20) @(posedge pclk);
        bo_low <= 1'b0;
        repeat (5) @(posedge pclk);
        chk("glitch flag", 1'b0, bo_flag);
        chk("glitch ignored", 1'b1, core_reset_n);
        bo_low <= 1'b1;
        repeat (200) @(posedge pclk);
        chk("brownout flag", 1'b1, bo_flag);
        chk("brownout hold", 1'b0, core_reset_n);
        bo_low <= 1'b0;
        wait_core(1'b1);
        chk("timer after bor", 1'b1, n >= 50);
        for (k = 0; k < 6; k++) begin
            req[k] <= 1'b1;
            repeat (4) @(posedge pclk);
            chk("source reset", 1'b0, core_reset_n);
            req[k] <= 1'b0;
            wait_core(1'b1);
            chk("release delay", 1'b1, n >= 10);
        end
        // timer disabled: a power-on style hold releases without the 50-cycle count
        cfg.power_up_timer_disable <= 1'b1;
        req[0] <= 1'b1;
        repeat (4) @(posedge pclk);
        chk("disabled hold", 1'b0, core_reset_n);
        req[0] <= 1'b0;
        wait_core(1'b1);
        chk("timer disabled", 1'b1, n < 30);
        test_done();
    end
endmodule
`default_nettype wire
